// ===== rtl/ciote_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts for the
 * camera I/O, timer and event unit. Assumes a 100 MHz device clock.
 */
`ifndef CIOTE_CFG_SVH
`define CIOTE_CFG_SVH

`define CIOTE_CLK_PERIOD_NS 10
`define CIOTE_TICK_NS       1000
`define CIOTE_TICK_CYC      (`CIOTE_TICK_NS / `CIOTE_CLK_PERIOD_NS)

`define CIOTE_N_UNIT        2
`define CIOTE_LB_INPUTS     4
`define CIOTE_SRC_W         4
`define CIOTE_SRC_LINE      0
`define CIOTE_SRC_USER      4
`define CIOTE_SRC_SWSIG     6
`define CIOTE_SRC_TIMER     8
`define CIOTE_SRC_LB        10
`define CIOTE_SRC_FTRIG     12
`define CIOTE_SRC_EXPO      13
`define CIOTE_SRC_FRAME     14
`define CIOTE_SRC_ZERO      15

`define CIOTE_EVT_PINL0_RISE 8
`define CIOTE_EVT_PINL0_FALL 9
`define CIOTE_EVT_PINL2_RISE 10
`define CIOTE_EVT_PINL2_FALL 11
`define CIOTE_EVT_NUM        12
`define CIOTE_EVT_EXT        8

`define CIOTE_RST_DEB       16'h0000
`define CIOTE_RST_SRC       4'hF
`define CIOTE_RST_TMR       16'h0000

`endif

// ===== rtl/ciote_debounce.sv
/*
 * Input line debouncer counting microsecond ticks.
 * Assumes i_raw is already synchronised to i_clk.
 */
`timescale 1ns/1ps
module ciote_debounce #(
  parameter int DEB_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_raw,
  input  wire logic             i_tick,
  input  wire logic [DEB_W-1:0] i_time,
  output logic                  o_lvl
);
  logic             lvl_q, lvl_d;
  logic [DEB_W-1:0] cnt_q, cnt_d;

  // A glitch shorter than the time restarts the count
  always_comb begin
    lvl_d = lvl_q;
    cnt_d = cnt_q;
    if (i_raw == lvl_q) begin
      cnt_d = '0;
    end else if (cnt_q >= i_time) begin
      lvl_d = i_raw;
      cnt_d = '0;
    end else if (i_tick) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_q <= 1'b0;
      cnt_q <= '0;
    end else begin
      lvl_q <= lvl_d;
      cnt_q <= cnt_d;
    end
  end

  assign o_lvl = lvl_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  deb_accept_a: assert property (
    $changed(lvl_q) |-> $past(cnt_q >= i_time && i_raw != lvl_q))
    else $error("debounced level changed before time");
endmodule : ciote_debounce

// ===== rtl/ciote_pkg.sv
/*
 * Types shared by the camera I/O, timer and event unit.
 * Assumes nothing beyond a SystemVerilog elaborator.
 */
package ciote_pkg;

  typedef enum logic [2:0] {
    ACT_OFF, ACT_RISE, ACT_FALL, ACT_ANY, ACT_HIGH, ACT_LOW
  } ciote_act_type;

  typedef enum logic {LB_AND, LB_OR} ciote_lbfunc_type;

  typedef enum logic [1:0] {TM_IDLE, TM_DELAY, TM_PULSE} ciote_tmst_type;

  // Activation test shared by counter resets and timer triggers
  function automatic logic act_hit(input ciote_act_type act,
                                   input logic cur,
                                   input logic prev);
    case (act)
      ACT_RISE: act_hit = cur & ~prev;
      ACT_FALL: act_hit = ~cur & prev;
      ACT_ANY:  act_hit = cur ^ prev;
      ACT_HIGH: act_hit = cur;
      ACT_LOW:  act_hit = ~cur;
      default:  act_hit = 1'b0;
    endcase
  endfunction : act_hit

endpackage : ciote_pkg

// ===== rtl/ciote_timer.sv
/*
 * One delay-then-pulse timer counted in microsecond ticks.
 * Assumes i_trig and i_tick are single-cycle pulses on i_clk.
 */
`timescale 1ns/1ps
module ciote_timer #(
  parameter int TMR_W = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_tick,
  input  wire logic             i_trig,
  input  wire logic [TMR_W-1:0] i_delay,
  input  wire logic [TMR_W-1:0] i_dur,
  input  wire logic             i_load,
  input  wire logic [TMR_W-1:0] i_load_val,
  output logic                  o_out,
  output logic [TMR_W-1:0]      o_value
);
  ciote_pkg::ciote_tmst_type st_q, st_d;
  logic [TMR_W-1:0]          rem_q, rem_d;

  // Tick is free running, so delay and duration carry up to 1 us jitter
  always_comb begin
    st_d  = st_q;
    rem_d = rem_q;
    case (st_q)
      ciote_pkg::TM_IDLE: begin
        if (i_trig && i_delay != '0) begin
          st_d  = ciote_pkg::TM_DELAY;
          rem_d = i_delay;
        end else if (i_trig && i_dur != '0) begin
          st_d  = ciote_pkg::TM_PULSE;
          rem_d = i_dur;
        end
      end
      ciote_pkg::TM_DELAY: begin
        if (i_tick && rem_q <= 1) begin
          st_d  = (i_dur != '0) ? ciote_pkg::TM_PULSE : ciote_pkg::TM_IDLE;
          rem_d = i_dur;
        end else if (i_tick) begin
          rem_d = rem_q - 1'b1;
        end
      end
      ciote_pkg::TM_PULSE: begin
        if (i_tick && rem_q <= 1) begin
          st_d  = ciote_pkg::TM_IDLE;
          rem_d = '0;
        end else if (i_tick) begin
          rem_d = rem_q - 1'b1;
        end
      end
      default: st_d = ciote_pkg::TM_IDLE;
    endcase
    if (i_load && st_q != ciote_pkg::TM_IDLE) begin
      rem_d = i_load_val;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q  <= ciote_pkg::TM_IDLE;
      rem_q <= '0;
    end else begin
      st_q  <= st_d;
      rem_q <= rem_d;
    end
  end

  assign o_out   = (st_q == ciote_pkg::TM_PULSE);
  assign o_value = rem_q;

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_arm;
    st_q == ciote_pkg::TM_IDLE && i_trig && i_delay != '0;
  endsequence
  sequence s_expire;
    st_q == ciote_pkg::TM_DELAY && i_tick && rem_q == 1 && !i_load;
  endsequence

  tmr_delay_a: assert property (
    s_arm |=> !o_out && rem_q == $past(i_delay))
    else $error("timer did not enter delay");
  tmr_pulse_a: assert property (
    s_expire ##0 (i_dur != '0) |=> o_out && rem_q == $past(i_dur))
    else $error("timer pulse did not start after delay");
endmodule : ciote_timer

// ===== rtl/ciote_top.sv
/*
 * Camera digital I/O unit: line control, logic blocks, software signals,
 * counters, timers and event notification gating.
 * Assumes config strobes and acquisition signals are on i_clk; line pins
 * are asynchronous.
 */
// Behaviour
// - Line selector picks which line the per-line settings apply to.
// - Per-line direction setting makes the line an input or an output.
// - An output line drives the internal signal picked by its source.
// - Inversion setting inverts the line signal for inputs and outputs.
// - Input lines are debounced; changes shorter than the time are dropped.
// - Line status returns the level of the selected line.
// - Status word holds every line level, registered on every clock.
// - Writing the user value changes only the selected user output bit.
// - Each logic block computes its selected combinational function.
// - Only the configured number of block inputs take part.
// - Each block input picks a source and may invert it.
// - Software signal pulse command emits one pulse on that signal.
// - A counter increments once per occurrence of its event source.
// - A counter clears when its reset source meets its activation.
// - Software counter reset clears the counter and starts it.
// - Selected counter value is readable and writable.
// - A timer waits its delay in microseconds after its trigger.
// - Then the timer holds its pulse for the duration in microseconds.
// - A timer starts when its trigger source meets its activation.
// - Selected timer value in microseconds is readable; writable only while the timer is not idle.
// - Each event notifies the host only while its enable is set.
// - Detect test, late, trigger, exposure, frame, discard, pin edges.
`timescale 1ns/1ps
`include "ciote_cfg.svh"
module ciote_top #(
  parameter int N_LINES = 4,
  parameter int DEB_W   = 16,
  parameter int CNT_W   = 32,
  parameter int TMR_W   = 16
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic [N_LINES-1:0]       i_line_pin,
  output logic      [N_LINES-1:0]       o_line_pin_out,
  output logic      [N_LINES-1:0]       o_line_pin_oe,
  input  wire logic [1:0]               i_line_sel,
  input  wire logic                     i_line_cfg_wr,
  input  wire logic                     i_line_mode,
  input  wire logic [`CIOTE_SRC_W-1:0]  i_line_src,
  input  wire logic                     i_line_inv,
  input  wire logic [DEB_W-1:0]         i_line_deb,
  output logic                          o_line_status,
  output logic      [N_LINES-1:0]       o_line_status_all,
  input  wire logic                     i_user_sel,
  input  wire logic                     i_user_wr,
  input  wire logic                     i_user_val,
  input  wire logic                     i_lb_sel,
  input  wire logic                     i_lb_wr,
  input  wire ciote_pkg::ciote_lbfunc_type i_lb_func,
  input  wire logic [2:0]               i_lb_num,
  input  wire logic [1:0]               i_lbi_sel,
  input  wire logic                     i_lbi_wr,
  input  wire logic [`CIOTE_SRC_W-1:0]  i_lbi_src,
  input  wire logic                     i_lbi_inv,
  input  wire logic                     i_swsig_sel,
  input  wire logic                     i_swsig_pulse,
  input  wire logic                     i_cnt_sel,
  input  wire logic                     i_cnt_cfg_wr,
  input  wire logic [`CIOTE_SRC_W-1:0]  i_cnt_ev_src,
  input  wire logic [`CIOTE_SRC_W-1:0]  i_cnt_rst_src,
  input  wire ciote_pkg::ciote_act_type i_cnt_rst_act,
  input  wire logic                     i_cnt_sw_rst,
  input  wire logic                     i_cnt_val_wr,
  input  wire logic [CNT_W-1:0]         i_cnt_val,
  output logic      [CNT_W-1:0]         o_cnt_val,
  input  wire logic                     i_tmr_sel,
  input  wire logic                     i_tmr_cfg_wr,
  input  wire logic [TMR_W-1:0]         i_tmr_delay,
  input  wire logic [TMR_W-1:0]         i_tmr_dur,
  input  wire logic [`CIOTE_SRC_W-1:0]  i_tmr_trg_src,
  input  wire ciote_pkg::ciote_act_type i_tmr_trg_act,
  input  wire logic                     i_tmr_val_wr,
  input  wire logic [TMR_W-1:0]         i_tmr_val,
  output logic      [TMR_W-1:0]         o_tmr_val,
  input  wire logic                     i_acq_ftrig,
  input  wire logic                     i_acq_expo,
  input  wire logic                     i_acq_frame,
  input  wire logic [`CIOTE_EVT_EXT-1:0] i_evt_src,
  input  wire logic [3:0]               i_evt_sel,
  input  wire logic                     i_evt_notif_wr,
  input  wire logic                     i_evt_notif_en,
  output logic      [`CIOTE_EVT_NUM-1:0] o_evt_notify
);
  localparam int NU = `CIOTE_N_UNIT;
  localparam int NI = `CIOTE_LB_INPUTS;
  localparam int SW = `CIOTE_SRC_W;

  if (N_LINES < 3 || N_LINES > 4) begin : g_bad_lines
    $error("N_LINES must be 3 or 4");
  end
  if (DEB_W < 1 || CNT_W < 1 || CNT_W > 32 || TMR_W < 1 || TMR_W > 32)
  begin : g_bad_width
    $error("unsupported counter or timer width");
  end

  // Tick generator
  logic [7:0] tick_cnt_q, tick_cnt_d;
  logic       tick_q, tick_d;
  always_comb begin
    tick_d     = (tick_cnt_q == 8'(`CIOTE_TICK_CYC - 1));
    tick_cnt_d = tick_d ? 8'h00 : tick_cnt_q + 8'h01;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_cnt_q <= 8'h00;
      tick_q     <= 1'b0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      tick_q     <= tick_d;
    end
  end

  // Pin synchronisers; stage one feeds only stage two
  logic [N_LINES-1:0] pin_s1_q, pin_s2_q, deb_lvl;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= i_line_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Line, user output and software signal configuration
  logic [N_LINES-1:0] mode_q, mode_d, inv_q, inv_d;
  logic [SW-1:0]      src_q [N_LINES];
  logic [SW-1:0]      src_d [N_LINES];
  logic [DEB_W-1:0]   deb_q [N_LINES];
  logic [DEB_W-1:0]   deb_d [N_LINES];
  logic [NU-1:0]      user_q, user_d, sw_q, sw_d;
  always_comb begin
    mode_d = mode_q;
    inv_d  = inv_q;
    src_d  = src_q;
    deb_d  = deb_q;
    user_d = user_q;
    sw_d   = '0;
    if (i_line_cfg_wr && 32'(i_line_sel) < N_LINES) begin
      mode_d[i_line_sel] = i_line_mode;
      inv_d[i_line_sel]  = i_line_inv;
      src_d[i_line_sel]  = i_line_src;
      deb_d[i_line_sel]  = i_line_deb;
    end
    if (i_user_wr) user_d[i_user_sel] = i_user_val;
    if (i_swsig_pulse) sw_d[i_swsig_sel] = 1'b1;
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= '0;
      inv_q  <= '0;
      user_q <= '0;
      sw_q   <= '0;
      for (int i = 0; i < N_LINES; i++) begin
        src_q[i] <= `CIOTE_RST_SRC;
        deb_q[i] <= DEB_W'(`CIOTE_RST_DEB);
      end
    end else begin
      mode_q <= mode_d;
      inv_q  <= inv_d;
      src_q  <= src_d;
      deb_q  <= deb_d;
      user_q <= user_d;
      sw_q   <= sw_d;
    end
  end

  for (genvar g = 0; g < N_LINES; g++) begin : g_deb
    ciote_debounce #(.DEB_W(DEB_W)) u_deb (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_raw  (pin_s2_q[g]),
      .i_tick (tick_q),
      .i_time (deb_q[g]),
      .o_lvl  (deb_lvl[g])
    );
  end

  // Internal signal bus; every internal entry is registered and acquisition inputs enter directly, so no loops form
  logic [15:0]        sig, sig_prev_q;
  logic [NU-1:0]      tmr_out, lb_q, lb_d;
  logic [N_LINES-1:0] in_lvl, out_val, line_lvl;
  always_comb begin
    in_lvl = deb_lvl ^ inv_q;
    sig = 16'h0000;
    sig[N_LINES-1:0] = in_lvl;
    sig[`CIOTE_SRC_USER +: NU]  = user_q;
    sig[`CIOTE_SRC_SWSIG +: NU] = sw_q;
    sig[`CIOTE_SRC_TIMER +: NU] = tmr_out;
    sig[`CIOTE_SRC_LB +: NU]    = lb_q;
    sig[`CIOTE_SRC_FTRIG] = i_acq_ftrig;
    sig[`CIOTE_SRC_EXPO]  = i_acq_expo;
    sig[`CIOTE_SRC_FRAME] = i_acq_frame;
    for (int i = 0; i < N_LINES; i++) begin
      out_val[i]  = sig[src_q[i]] ^ inv_q[i];
      line_lvl[i] = mode_q[i] ? out_val[i] : in_lvl[i];
    end
  end

  // Logic blocks
  ciote_pkg::ciote_lbfunc_type lbf_q [NU];
  ciote_pkg::ciote_lbfunc_type lbf_d [NU];
  logic [2:0]    lbn_q [NU];
  logic [2:0]    lbn_d [NU];
  logic [SW-1:0] lbs_q [NU][NI];
  logic [SW-1:0] lbs_d [NU][NI];
  logic [NI-1:0] lbv_q [NU];
  logic [NI-1:0] lbv_d [NU];
  always_comb begin
    lbf_d = lbf_q;
    lbn_d = lbn_q;
    lbs_d = lbs_q;
    lbv_d = lbv_q;
    if (i_lb_wr) begin
      lbf_d[i_lb_sel] = i_lb_func;
      lbn_d[i_lb_sel] = i_lb_num;
    end
    if (i_lbi_wr) begin
      lbs_d[i_lb_sel][i_lbi_sel] = i_lbi_src;
      lbv_d[i_lb_sel][i_lbi_sel] = i_lbi_inv;
    end
    for (int b = 0; b < NU; b++) begin
      lb_d[b] = (lbf_q[b] == ciote_pkg::LB_AND) && (lbn_q[b] != 3'h0);
      for (int k = 0; k < NI; k++) begin
        if (3'(k) < lbn_q[b]) begin
          if (lbf_q[b] == ciote_pkg::LB_AND)
            lb_d[b] = lb_d[b] & (sig[lbs_q[b][k]] ^ lbv_q[b][k]);
          else
            lb_d[b] = lb_d[b] | (sig[lbs_q[b][k]] ^ lbv_q[b][k]);
        end
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lb_q <= '0;
      for (int b = 0; b < NU; b++) begin
        lbf_q[b] <= ciote_pkg::LB_AND;
        lbn_q[b] <= 3'h0;
        lbv_q[b] <= '0;
        for (int k = 0; k < NI; k++) lbs_q[b][k] <= `CIOTE_RST_SRC;
      end
    end else begin
      lb_q  <= lb_d;
      lbf_q <= lbf_d;
      lbn_q <= lbn_d;
      lbs_q <= lbs_d;
      lbv_q <= lbv_d;
    end
  end

  // Counters: hardware clear beats software reset beats load beats count
  logic [SW-1:0]            cev_q [NU];
  logic [SW-1:0]            cev_d [NU];
  logic [SW-1:0]            crs_q [NU];
  logic [SW-1:0]            crs_d [NU];
  ciote_pkg::ciote_act_type cra_q [NU];
  ciote_pkg::ciote_act_type cra_d [NU];
  logic [CNT_W-1:0]         cnt_q [NU];
  logic [CNT_W-1:0]         cnt_d [NU];
  logic [NU-1:0]            run_q, run_d, hw_clr, ev_hit;
  always_comb begin
    cev_d = cev_q;
    crs_d = crs_q;
    cra_d = cra_q;
    cnt_d = cnt_q;
    run_d = run_q;
    if (i_cnt_cfg_wr) begin
      cev_d[i_cnt_sel] = i_cnt_ev_src;
      crs_d[i_cnt_sel] = i_cnt_rst_src;
      cra_d[i_cnt_sel] = i_cnt_rst_act;
    end
    for (int c = 0; c < NU; c++) begin
      hw_clr[c] = ciote_pkg::act_hit(cra_q[c], sig[crs_q[c]],
                                     sig_prev_q[crs_q[c]]);
      ev_hit[c] = sig[cev_q[c]] & ~sig_prev_q[cev_q[c]];
      if (hw_clr[c]) begin
        cnt_d[c] = '0;
      end else if (i_cnt_sw_rst && i_cnt_sel == 1'(c)) begin
        cnt_d[c] = '0;
        run_d[c] = 1'b1;
      end else if (i_cnt_val_wr && i_cnt_sel == 1'(c)) begin
        cnt_d[c] = i_cnt_val;
      end else if (run_q[c] && ev_hit[c]) begin
        cnt_d[c] = cnt_q[c] + 1'b1;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_q <= '1;
      for (int c = 0; c < NU; c++) begin
        cev_q[c] <= `CIOTE_RST_SRC;
        crs_q[c] <= `CIOTE_RST_SRC;
        cra_q[c] <= ciote_pkg::ACT_OFF;
        cnt_q[c] <= '0;
      end
    end else begin
      run_q <= run_d;
      cev_q <= cev_d;
      crs_q <= crs_d;
      cra_q <= cra_d;
      cnt_q <= cnt_d;
    end
  end

  // Timers
  logic [TMR_W-1:0]         tdl_q [NU];
  logic [TMR_W-1:0]         tdl_d [NU];
  logic [TMR_W-1:0]         tdu_q [NU];
  logic [TMR_W-1:0]         tdu_d [NU];
  logic [TMR_W-1:0]         tval [NU];
  logic [SW-1:0]            tts_q [NU];
  logic [SW-1:0]            tts_d [NU];
  ciote_pkg::ciote_act_type tta_q [NU];
  ciote_pkg::ciote_act_type tta_d [NU];
  logic [NU-1:0]            t_trig;
  always_comb begin
    tdl_d = tdl_q;
    tdu_d = tdu_q;
    tts_d = tts_q;
    tta_d = tta_q;
    if (i_tmr_cfg_wr) begin
      tdl_d[i_tmr_sel] = i_tmr_delay;
      tdu_d[i_tmr_sel] = i_tmr_dur;
      tts_d[i_tmr_sel] = i_tmr_trg_src;
      tta_d[i_tmr_sel] = i_tmr_trg_act;
    end
    for (int t = 0; t < NU; t++)
      t_trig[t] = ciote_pkg::act_hit(tta_q[t], sig[tts_q[t]],
                                     sig_prev_q[tts_q[t]]);
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int t = 0; t < NU; t++) begin
        tdl_q[t] <= TMR_W'(`CIOTE_RST_TMR);
        tdu_q[t] <= TMR_W'(`CIOTE_RST_TMR);
        tts_q[t] <= `CIOTE_RST_SRC;
        tta_q[t] <= ciote_pkg::ACT_OFF;
      end
    end else begin
      tdl_q <= tdl_d;
      tdu_q <= tdu_d;
      tts_q <= tts_d;
      tta_q <= tta_d;
    end
  end
  for (genvar g = 0; g < NU; g++) begin : g_tmr
    ciote_timer #(.TMR_W(TMR_W)) u_tmr (
      .i_clk      (i_clk),
      .i_rst      (i_rst),
      .i_tick     (tick_q),
      .i_trig     (t_trig[g]),
      .i_delay    (tdl_q[g]),
      .i_dur      (tdu_q[g]),
      .i_load     (i_tmr_val_wr && i_tmr_sel == 1'(g)),
      .i_load_val (i_tmr_val),
      .o_out      (tmr_out[g]),
      .o_value    (tval[g])
    );
  end

  // Events and registered outputs
  logic [`CIOTE_EVT_NUM-1:0] notif_q, notif_d, evt;
  always_comb begin
    notif_d = notif_q;
    if (i_evt_notif_wr && 32'(i_evt_sel) < `CIOTE_EVT_NUM)
      notif_d[i_evt_sel] = i_evt_notif_en;
    evt = {~sig[2] & sig_prev_q[2], sig[2] & ~sig_prev_q[2],
           ~sig[0] & sig_prev_q[0], sig[0] & ~sig_prev_q[0], i_evt_src};
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      notif_q           <= '0;
      sig_prev_q        <= 16'h0000;
      o_evt_notify      <= '0;
      o_line_pin_out    <= '0;
      o_line_pin_oe     <= '0;
      o_line_status     <= 1'b0;
      o_line_status_all <= '0;
      o_cnt_val         <= '0;
      o_tmr_val         <= '0;
    end else begin
      notif_q           <= notif_d;
      sig_prev_q        <= sig;
      o_evt_notify      <= evt & notif_q;
      o_line_pin_out    <= out_val & mode_q;
      o_line_pin_oe     <= mode_q;
      o_line_status     <= line_lvl[i_line_sel];
      o_line_status_all <= line_lvl;
      o_cnt_val         <= cnt_q[i_cnt_sel];
      o_tmr_val         <= tval[i_tmr_sel];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  tick_period_a: assert property (tick_q |=> !tick_q ##99 tick_q)
    else $error("tick period is not 100 cycles");
  line_drive_a: assert property (mode_q[0] |=> o_line_pin_oe[0]
    && o_line_pin_out[0] == $past(sig[src_q[0]] ^ inv_q[0]))
    else $error("output line does not drive its source");
  line_dir_a: assert property (!mode_q[1] |=> !o_line_pin_oe[1])
    else $error("input line is driven");
  status_all_a: assert property (o_line_pin_oe[1] |->
    o_line_status_all[1] == o_line_pin_out[1])
    else $error("status word mismatch");
  user_bit_a: assert property (i_user_wr |=>
    user_q[$past(i_user_sel)] == $past(i_user_val)
    && user_q[!$past(i_user_sel)] == $past(user_q[!i_user_sel]))
    else $error("user write touched the wrong bit");
  sw_pulse_a: assert property (
    i_swsig_pulse && !i_swsig_sel ##1 !i_swsig_pulse |-> sw_q[0] ##1 !sw_q[0])
    else $error("software pulse not single");
  cnt_swrst_a: assert property (
    i_cnt_sw_rst && !i_cnt_sel && !hw_clr[0] |=> cnt_q[0] == '0 && run_q[0])
    else $error("software reset did not clear and start");
  cnt_hwclr_a: assert property (hw_clr[0] |=> cnt_q[0] == '0)
    else $error("counter not cleared by reset source");
  cnt_incr_a: assert property (
    run_q[0] && ev_hit[0] && !hw_clr[0] && !((i_cnt_sw_rst || i_cnt_val_wr)
    && !i_cnt_sel) |=> cnt_q[0] == $past(cnt_q[0]) + 1'b1)
    else $error("counter missed its event");
  evt_gate_a: assert property (
    o_evt_notify[8] |-> $past(evt[8] && notif_q[8]))
    else $error("event sent while disabled");
endmodule : ciote_top

// ===== verification/ciote_line_model.sv
/* External connector lines seen from outside the camera.
   Assumes one pin per line and a pull-down where nothing drives. */
`timescale 1ns/1ps
module ciote_line_model (
  input  wire logic [3:0] i_out,
  input  wire logic [3:0] i_oe,
  input  wire logic [3:0] i_ext,
  output logic      [3:0] o_pin
);
  // Camera wins while it drives; else the outside source
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      o_pin[k] = i_oe[k] ? i_out[k] : i_ext[k];
    end
  end
endmodule : ciote_line_model

// ===== verification/tb.sv
/* Self-checking bench for ciote_top through its config strobes.
   Assumes the rtl files and the line model are compiled first. */
`timescale 1ns/1ps
module tb;
  logic        i_clk = 0, i_rst = 1, i_line_cfg_wr = 0, i_line_mode = 0;
  logic        i_line_inv = 0, i_user_sel = 0, i_user_wr = 0, i_user_val = 0;
  logic        i_lb_sel = 0, i_lb_wr = 0, i_lbi_wr = 0, i_lbi_inv = 0;
  logic        i_swsig_sel = 0, i_swsig_pulse = 0, i_cnt_sel = 0;
  logic        i_cnt_cfg_wr = 0, i_cnt_sw_rst = 0, i_cnt_val_wr = 0;
  logic        i_tmr_sel = 0, i_tmr_cfg_wr = 0, i_tmr_val_wr = 0;
  logic        i_acq_ftrig = 0, i_acq_expo = 0, i_acq_frame = 0;
  logic        i_evt_notif_wr = 0, i_evt_notif_en = 0, o_line_status;
  logic [1:0]  i_line_sel = 0, i_lbi_sel = 0;
  logic [2:0]  i_lb_num = 0;
  logic [3:0]  i_line_src = 0, i_lbi_src = 0, i_cnt_ev_src = 0, ext = 0;
  logic [3:0]  i_cnt_rst_src = 0, i_tmr_trg_src = 0, i_evt_sel = 0;
  logic [7:0]  i_evt_src = 0;
  logic [15:0] i_line_deb = 0, i_tmr_delay = 0, i_tmr_dur = 0, i_tmr_val = 0;
  logic [31:0] i_cnt_val = 0, o_cnt_val;
  logic [15:0] o_tmr_val;
  logic [11:0] o_evt_notify;
  logic [3:0]  i_line_pin, o_line_pin_out, o_line_pin_oe, o_line_status_all;
  ciote_pkg::ciote_lbfunc_type i_lb_func = ciote_pkg::LB_AND;
  ciote_pkg::ciote_act_type    i_cnt_rst_act = ciote_pkg::ACT_OFF;
  ciote_pkg::ciote_act_type    i_tmr_trg_act = ciote_pkg::ACT_OFF;
  int          err_count = 0, compares = 0, cyc = 0, n8 = 0, n0 = 0, hi = 0;

  ciote_top dut (.*);
  ciote_line_model lines (.i_out(o_line_pin_out), .i_oe(o_line_pin_oe),
                          .i_ext(ext), .o_pin(i_line_pin));

  initial forever #5 i_clk = ~i_clk;

  // Pulse tallies; also cuts a hang short
  always @(negedge i_clk) begin
    cyc++;
    n8 += o_evt_notify[8];
    n0 += o_evt_notify[0];
    hi += o_line_pin_out[2];
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic step(int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : step

  task automatic strobe(ref logic s);
    s = 1'h1;
    step(1);
    s = 1'h0;
  endtask : strobe

  task automatic chk(logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic line(logic [1:0] n, logic m, logic [3:0] src, logic v);
    i_line_sel = n;
    i_line_mode = m;
    i_line_src = src;
    i_line_inv = v;
    strobe(i_line_cfg_wr);
  endtask : line

  task automatic wrap_up();
    $display("Compares %0d, errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  initial begin
    step(4);
    i_rst = 0;
    line(1, 1, 4'h5, 0);
    i_user_sel = 1;
    i_user_val = 1;
    strobe(i_user_wr);
    step(2);
    chk(o_line_pin_oe, 4'h2);
    chk(o_line_pin_out[1], 1'h1);
    chk(o_line_status, 1'h1);
    i_user_sel = 0;
    i_user_val = 0;
    strobe(i_user_wr);
    line(1, 1, 4'h5, 1);
    step(2);
    chk(o_line_pin_out[1], 1'h0);
    $display("Line output test done");
    i_cnt_ev_src = 4'h6;
    strobe(i_cnt_cfg_wr);
    strobe(i_swsig_pulse);
    step(1);
    strobe(i_swsig_pulse);
    step(3);
    chk(o_cnt_val, 32'h2);
    i_cnt_val = 32'h5;
    strobe(i_cnt_val_wr);
    step(1);
    chk(o_cnt_val, 32'h5);
    strobe(i_cnt_sw_rst);
    step(1);
    chk(o_cnt_val, 32'h0);
    strobe(i_swsig_pulse);
    i_cnt_rst_src = 4'h6;
    i_cnt_rst_act = ciote_pkg::ACT_RISE;
    strobe(i_cnt_cfg_wr);
    strobe(i_swsig_pulse);
    step(3);
    chk(o_cnt_val, 32'h0);
    $display("Counter test done");
    line(2, 1, 4'h8, 0);
    i_tmr_delay = 16'h2;
    i_tmr_dur = 16'h3;
    i_tmr_trg_src = 4'h6;
    i_tmr_trg_act = ciote_pkg::ACT_RISE;
    strobe(i_tmr_cfg_wr);
    hi = 0;
    strobe(i_swsig_pulse);
    step(90);
    chk(o_line_pin_out[2], 1'h0);
    i_tmr_val = 16'h3;
    strobe(i_tmr_val_wr);
    step(1);
    chk(o_tmr_val, 32'h3);
    step(700);
    chk(hi >= 200 && hi <= 300, 1'h1);
    $display("Timer test done");
    i_line_deb = 16'h2;
    line(0, 0, 4'hF, 0);
    i_evt_sel = 4'h8;
    i_evt_notif_en = 1;
    strobe(i_evt_notif_wr);
    n8 = 0;
    ext[0] = 1;
    step(50);
    ext[0] = 0;
    step(400);
    chk(n8, 0);
    ext[0] = 1;
    step(400);
    chk(o_line_status_all, 4'h1);
    chk(n8, 1);
    n0 = 0;
    i_evt_src = 8'h01;
    step(1);
    i_evt_src = 8'h00;
    step(2);
    chk(n0, 0);
    $display("Input and event test done");
    i_lb_num = 3'h1;
    strobe(i_lb_wr);
    i_lbi_src = 4'hF;
    i_lbi_inv = 1;
    strobe(i_lbi_wr);
    line(3, 1, 4'hA, 0);
    step(3);
    chk(o_line_pin_out[3], 1'h1);
    i_lb_num = 3'h2;
    strobe(i_lb_wr);
    step(3);
    chk(o_line_pin_out[3], 1'h0);
    i_lb_func = ciote_pkg::LB_OR;
    strobe(i_lb_wr);
    step(3);
    chk(o_line_pin_out[3], 1'h1);
    $display("Logic block test done");
    wrap_up();
  end
endmodule : tb
